// ===== pcl_axis_model.sv
// Far-side model: axis position sources and the fast capture contact
`timescale 1ns/10ps
module pcl_axis_model (
    input  wire logic   clk_sys_in,
    output logic [31:0] enc_pos_out,
    output logic [31:0] scale_pos_out,
    output logic [31:0] pulse_pos_out,
    output logic        fast_capture_input_out
);
    logic idle_level = 1'b0;
    initial begin
        enc_pos_out = 32'h0;
        scale_pos_out = 32'h0;
        pulse_pos_out = 32'h0;
        fast_capture_input_out = 1'b0;
    end
    // Positions move only between triggers, so every latch has one right answer
    task automatic set_pos(input logic [31:0] e, input logic [31:0] s, input logic [31:0] p);
        @(posedge clk_sys_in);
        enc_pos_out <= e;
        scale_pos_out <= s;
        pulse_pos_out <= p;
    endtask
    task automatic set_idle(input logic lvl);
        @(posedge clk_sys_in);
        idle_level <= lvl;
        fast_capture_input_out <= lvl;
    endtask
    // Contact acts for four cycles, then returns to rest
    task automatic fire();
        @(posedge clk_sys_in);
        fast_capture_input_out <= ~idle_level;
        repeat (4) @(posedge clk_sys_in);
        fast_capture_input_out <= idle_level;
    endtask
endmodule

// ===== pcl_consts.vh
// Register map, field layout and timing constants of the position capture latch
// What this block does
// - Latch position from one selectable source axis
// - Refuse source change while compare uses capture
// - Data array holds up to 800 entries
// - Trigger only from fast input, within 5us
// - No software path generates a trigger
// - Fast input reaches capture regardless of mapping
// - Run start forces input mapping to 0x0100
// - Forced mapping not kept; default after reset
// - Edge trigger, contact polarity selectable
// - Several captures per run, one per edge
// - Programmable lockout after each capture
// - Each entry is signed 32-bit pulse count
// - Control bit 0 enables; cleared on completion
// - Remaining count decrements; zero ends run
// - Done output asserts after last capture
`ifndef PCL_CONSTS_VH
`define PCL_CONSTS_VH

`define PCL_OFF_CTRL      8'h00
`define PCL_OFF_SRC       8'h04
`define PCL_OFF_COUNT     8'h08
`define PCL_OFF_START     8'h0c
`define PCL_OFF_LOCKOUT   8'h10
`define PCL_OFF_IFMAP     8'h14
`define PCL_OFF_INT_STAT  8'h18
`define PCL_OFF_INT_MASK  8'h1c
`define PCL_OFF_RD_INDEX  8'h20
`define PCL_OFF_RD_DATA   8'h24
`define PCL_OFF_STATUS    8'h28

`define PCL_CTRL_EN_BIT   0
`define PCL_CTRL_POL_BIT  1

`define PCL_SRC_ENC       2'h0
`define PCL_SRC_SCALE     2'h1
`define PCL_SRC_PULSE     2'h2
`define PCL_SRC_BAD       2'h3

`define PCL_IRQ_CAPTURE   0
`define PCL_IRQ_DONE      1
`define PCL_IRQ_OVERFLOW  2
`define PCL_IRQ_W         3

`define PCL_IFMAP_FORCED  16'h0100
`define PCL_IFMAP_RESET   16'h0000

`define PCL_CLK_PERIOD_NS 50
`define PCL_RESPONSE_NS   5000
`define PCL_PATH_CYC      4

`endif

// ===== pcl_mem.v
// Capture data array: one write port, one read port with registered read data
`timescale 1ns/10ps
module pcl_mem #(
    parameter DW    = 32,
    parameter AW    = 10,
    parameter DEPTH = 800
) (
    input  wire          clk_sys_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem_reg [0:DEPTH-1];

    always @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_reg[rd_addr_in];
    end
endmodule

// ===== pcl_top.v
// Position capture latch: APB registers, trigger path, capture sequencing
`timescale 1ns/10ps
`include "pcl_consts.vh"
module pcl_top #(
    parameter DEPTH     = 800,
    parameter AW        = 10,
    parameter LOCK_W    = 16,
    parameter IFMAP_DEF = 16'h0000
) (
    input  wire        clk_sys_in,
    input  wire        sys_rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire        pready_out,
    output wire        pslverr_out,
    output reg  [31:0] prdata_out,
    input  wire        fast_capture_input_in,
    input  wire [31:0] enc_pos_in,
    input  wire [31:0] scale_pos_in,
    input  wire [31:0] pulse_pos_in,
    input  wire        compare_uses_capture_in,
    output reg  [15:0] input_function_map_out,
    output reg         capture_done_output_out,
    output wire        irq_out
);
    localparam [AW-1:0]     LAST_IDX   = DEPTH - 1;
    localparam [AW-1:0]     IDX_ONE    = 1;
    localparam [LOCK_W-1:0] LOCK_ZERO  = 0;
    localparam [LOCK_W-1:0] LOCK_ONE   = 1;
    localparam [AW-1:0]     CNT_ZERO   = 0;
    localparam              RESP_CYC   = `PCL_RESPONSE_NS / `PCL_CLK_PERIOD_NS;
    localparam              PATH_CYC   = `PCL_PATH_CYC;

    // Trigger path latency from pin to array write must fit the response time
    localparam              PATH_OK    = (PATH_CYC <= RESP_CYC) ? 1 : 0;

    reg                 run_reg;
    reg                 pol_reg;
    reg [1:0]           src_reg;
    reg [AW-1:0]        count_reg;
    reg [AW-1:0]        start_reg;
    reg [AW-1:0]        wr_idx_reg;
    reg [LOCK_W-1:0]    lockout_reg;
    reg [LOCK_W-1:0]    lock_cnt_reg;
    reg [AW-1:0]        rd_index_reg;
    reg [`PCL_IRQ_W-1:0] int_stat_reg;
    reg [`PCL_IRQ_W-1:0] int_mask_reg;
    reg                 sync1_reg;
    reg                 sync2_reg;
    reg                 sync3_reg;
    reg [31:0]          pos_sel;

    wire [31:0]         rd_data;
    wire                setup_phase;
    wire                wr_acc;
    wire                addr_ok;
    wire                rise;
    wire                fall;
    wire                trig_edge;
    wire                cap_fire;
    wire                last_cap;
    wire                idx_end;
    wire                start_req;
    wire                stop_req;
    wire                start_ok;
    wire                start_bad;
    wire [`PCL_IRQ_W-1:0] events;
    wire [`PCL_IRQ_W-1:0] w1c;

    assign setup_phase = psel_in & ~penable_in;
    assign pready_out  = psel_in & penable_in & (PATH_OK == 1);
    assign wr_acc      = psel_in & penable_in & pwrite_in & addr_ok;

    assign addr_ok = (paddr_in == `PCL_OFF_CTRL) | (paddr_in == `PCL_OFF_SRC) |
                     (paddr_in == `PCL_OFF_COUNT) | (paddr_in == `PCL_OFF_START) |
                     (paddr_in == `PCL_OFF_LOCKOUT) | (paddr_in == `PCL_OFF_IFMAP) |
                     (paddr_in == `PCL_OFF_INT_STAT) | (paddr_in == `PCL_OFF_INT_MASK) |
                     (paddr_in == `PCL_OFF_RD_INDEX) | (paddr_in == `PCL_OFF_RD_DATA) |
                     (paddr_in == `PCL_OFF_STATUS);
    assign pslverr_out = psel_in & penable_in & ~addr_ok;

    // Pin sampled twice before the edge detector looks at it
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= fast_capture_input_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rise      = sync2_reg & ~sync3_reg;
    assign fall      = ~sync2_reg & sync3_reg;
    // Normally-open contact fires on rising edge, normally-closed on falling
    assign trig_edge = pol_reg ? fall : rise;
    assign cap_fire  = run_reg & trig_edge & (lock_cnt_reg == LOCK_ZERO);
    assign last_cap  = cap_fire & (count_reg == IDX_ONE);
    assign idx_end   = cap_fire & ~last_cap & (wr_idx_reg == LAST_IDX);

    assign start_req = wr_acc & (paddr_in == `PCL_OFF_CTRL) & pwdata_in[`PCL_CTRL_EN_BIT] & ~run_reg;
    assign stop_req  = wr_acc & (paddr_in == `PCL_OFF_CTRL) & ~pwdata_in[`PCL_CTRL_EN_BIT] & run_reg;
    assign start_ok  = start_req & (count_reg != CNT_ZERO) & (start_reg <= LAST_IDX);
    assign start_bad = start_req & (count_reg != CNT_ZERO) & (start_reg > LAST_IDX);

    // Selected source position, live
    always @* begin
        case (src_reg)
            `PCL_SRC_ENC:   pos_sel = enc_pos_in;
            `PCL_SRC_SCALE: pos_sel = scale_pos_in;
            `PCL_SRC_PULSE: pos_sel = pulse_pos_in;
            default:        pos_sel = enc_pos_in;
        endcase
    end

    pcl_mem #(
        .DW    (32),
        .AW    (AW),
        .DEPTH (DEPTH)
    ) u_mem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (cap_fire),
        .wr_addr_in  (wr_idx_reg),
        .wr_data_in  (pos_sel),
        .rd_addr_in  (rd_index_reg),
        .rd_data_out (rd_data)
    );

    // Capture sequencing and software registers
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            run_reg                 <= 1'b0;
            pol_reg                 <= 1'b0;
            src_reg                 <= `PCL_SRC_ENC;
            count_reg               <= CNT_ZERO;
            start_reg               <= CNT_ZERO;
            wr_idx_reg              <= CNT_ZERO;
            lockout_reg             <= LOCK_ZERO;
            lock_cnt_reg            <= LOCK_ZERO;
            rd_index_reg            <= CNT_ZERO;
            input_function_map_out  <= IFMAP_DEF;
            capture_done_output_out <= 1'b0;
        end else begin
            if (wr_acc & (paddr_in == `PCL_OFF_CTRL)) begin
                pol_reg <= pwdata_in[`PCL_CTRL_POL_BIT];
            end
            if (wr_acc & (paddr_in == `PCL_OFF_SRC) & ~compare_uses_capture_in & ~run_reg &
                (pwdata_in[1:0] != `PCL_SRC_BAD)) begin
                src_reg <= pwdata_in[1:0];
            end
            if (wr_acc & (paddr_in == `PCL_OFF_START) & ~run_reg) begin
                start_reg <= pwdata_in[AW-1:0];
            end
            if (wr_acc & (paddr_in == `PCL_OFF_LOCKOUT)) begin
                lockout_reg <= pwdata_in[LOCK_W-1:0];
            end
            if (wr_acc & (paddr_in == `PCL_OFF_RD_INDEX)) begin
                rd_index_reg <= pwdata_in[AW-1:0];
            end
            if (start_ok) begin
                input_function_map_out <= `PCL_IFMAP_FORCED;
            end else if (wr_acc & (paddr_in == `PCL_OFF_IFMAP) & ~run_reg) begin
                input_function_map_out <= pwdata_in[15:0];
            end

            if (cap_fire) begin
                count_reg <= count_reg - IDX_ONE;
            end else if (wr_acc & (paddr_in == `PCL_OFF_COUNT) & ~run_reg) begin
                count_reg <= pwdata_in[AW-1:0];
            end

            if (start_ok) begin
                wr_idx_reg <= start_reg;
            end else if (cap_fire) begin
                wr_idx_reg <= wr_idx_reg + IDX_ONE;
            end

            if (cap_fire) begin
                lock_cnt_reg <= lockout_reg;
            end else if (lock_cnt_reg != LOCK_ZERO) begin
                lock_cnt_reg <= lock_cnt_reg - LOCK_ONE;
            end

            if (start_ok) begin
                run_reg <= 1'b1;
            end else if (last_cap | idx_end | stop_req) begin
                run_reg <= 1'b0;
            end

            if (last_cap) begin
                capture_done_output_out <= 1'b1;
            end else if (start_req) begin
                capture_done_output_out <= 1'b0;
            end
        end
    end

    assign events = {start_bad | idx_end, last_cap, cap_fire};
    assign w1c    = (wr_acc & (paddr_in == `PCL_OFF_INT_STAT)) ? pwdata_in[`PCL_IRQ_W-1:0]
                                                                : {`PCL_IRQ_W{1'b0}};

    // Interrupt status: a new event wins over a simultaneous clear
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            int_stat_reg <= {`PCL_IRQ_W{1'b0}};
            int_mask_reg <= {`PCL_IRQ_W{1'b0}};
        end else begin
            int_stat_reg <= (int_stat_reg & ~w1c) | events;
            if (wr_acc & (paddr_in == `PCL_OFF_INT_MASK)) begin
                int_mask_reg <= pwdata_in[`PCL_IRQ_W-1:0];
            end
        end
    end

    assign irq_out = |(int_stat_reg & int_mask_reg);

    // Read data registered in the setup cycle, presented in the access cycle
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_phase & ~pwrite_in) begin
            case (paddr_in)
                `PCL_OFF_CTRL:     prdata_out <= {30'h0, pol_reg, run_reg};
                `PCL_OFF_SRC:      prdata_out <= {30'h0, src_reg};
                `PCL_OFF_COUNT:    prdata_out <= {{(32-AW){1'b0}}, count_reg};
                `PCL_OFF_START:    prdata_out <= {{(32-AW){1'b0}}, start_reg};
                `PCL_OFF_LOCKOUT:  prdata_out <= {{(32-LOCK_W){1'b0}}, lockout_reg};
                `PCL_OFF_IFMAP:    prdata_out <= {16'h0, input_function_map_out};
                `PCL_OFF_INT_STAT: prdata_out <= {{(32-`PCL_IRQ_W){1'b0}}, int_stat_reg};
                `PCL_OFF_INT_MASK: prdata_out <= {{(32-`PCL_IRQ_W){1'b0}}, int_mask_reg};
                `PCL_OFF_RD_INDEX: prdata_out <= {{(32-AW){1'b0}}, rd_index_reg};
                `PCL_OFF_RD_DATA:  prdata_out <= rd_data;
                `PCL_OFF_STATUS:   prdata_out <= {{(16-AW){1'b0}}, wr_idx_reg, 13'h0, compare_uses_capture_in,
                                                  capture_done_output_out, run_reg};
                default:           prdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== pcl_top_sva.sv
// Port-level assertion checker for the position capture latch
`timescale 1ns/10ps
module pcl_top_chk (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [31:0] prdata_out,
    input wire logic        fast_capture_input_in,
    input wire logic [31:0] enc_pos_in,
    input wire logic [31:0] scale_pos_in,
    input wire logic [31:0] pulse_pos_in,
    input wire logic        compare_uses_capture_in,
    input wire logic [15:0] input_function_map_out,
    input wire logic        capture_done_output_out,
    input wire logic        irq_out
);
    wire wr_acc = psel_in && penable_in && pwrite_in;
    wire ctrl_wr = wr_acc && paddr_in == 8'h00;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    chk_ready_access:
        assert property (pready_out == (psel_in && penable_in)) else $error("pready off access phase");
    chk_err_unmapped:
        assert property (psel_in && penable_in && paddr_in > 8'h28 |-> pslverr_out) else $error("no error on hole");
    chk_err_rdata:
        assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("data from hole");
    chk_map_reset:
        assert property ($fell(sys_rst_in) |-> input_function_map_out == 16'h0000) else $error("map not default");
    chk_map_forced:
        assert property ($changed(input_function_map_out) && $past(paddr_in) == 8'h00
            |-> input_function_map_out == 16'h0100) else $error("start did not force map");
    chk_map_write:
        assert property ($changed(input_function_map_out) |-> $past(wr_acc)) else $error("map changed alone");
    chk_done_clear:
        assert property (ctrl_wr && pwdata_in[0] |=> !capture_done_output_out) else $error("done not cleared");
    chk_done_hold:
        assert property (capture_done_output_out && !ctrl_wr |=> capture_done_output_out) else $error("done lost");
    chk_done_cause:
        assert property ($rose(capture_done_output_out)
            |-> $past(fast_capture_input_in, 2) != $past(fast_capture_input_in, 3)
            || $past(fast_capture_input_in, 3) != $past(fast_capture_input_in, 4)
            || $past(fast_capture_input_in, 4) != $past(fast_capture_input_in, 5)) else $error("done without edge");
    chk_irq_reset:
        assert property ($past(sys_rst_in) |-> !irq_out) else $error("irq after reset");
    cov_done: cover property ($rose(capture_done_output_out));
    cov_forced: cover property (input_function_map_out == 16'h0100);
    cov_hole: cover property (pslverr_out);
endmodule

bind pcl_top pcl_top_chk pcl_top_chk_inst (.clk_sys_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .fast_capture_input_in, .enc_pos_in, .scale_pos_in,
    .pulse_pos_in, .compare_uses_capture_in, .input_function_map_out, .capture_done_output_out, .irq_out);

// ===== position_capture_latch_tb_top.sv
// Self-checking testbench of the position capture latch
`timescale 1ns/10ps
`include "pcl_consts.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module position_capture_latch_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic        compare_uses_capture_in = 1'b0;
    logic [31:0] seed = 32'd56425;
    wire         pready_out, pslverr_out, done, irq_out, pin;
    wire  [31:0] prdata_out, enc, scale, pulse;
    wire  [15:0] ifmap;
    int          miscompares = 0;
    int          cmp_count = 0;
    typedef struct {logic [31:0] e; logic [31:0] m; logic err;} pcl_note_t;
    pcl_note_t   notes[$];

    pcl_top pcl_top_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out), .fast_capture_input_in(pin),
        .enc_pos_in(enc), .scale_pos_in(scale), .pulse_pos_in(pulse), .compare_uses_capture_in(compare_uses_capture_in),
        .input_function_map_out(ifmap), .capture_done_output_out(done), .irq_out(irq_out));
    pcl_axis_model pcl_axis_model_inst (.clk_sys_in(clk_sys_in), .enc_pos_out(enc), .scale_pos_out(scale),
        .pulse_pos_out(pulse), .fast_capture_input_out(pin));

    initial forever #25 clk_sys_in = ~clk_sys_in;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
        notes.push_back('{e, m, err});
        apb(1'b0, a, 32'h0);
    endtask
    // Waits at falling edges, where registered outputs have settled
    task automatic look(input logic want_done, input logic ex, input int lim);
        int n = 1;
        @(negedge clk_sys_in);
        while ((want_done ? done : irq_out) !== ex && n++ < lim) @(negedge clk_sys_in);
        `CHK("output", ex, want_done ? done : irq_out)
        @(posedge clk_sys_in);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && notes.size() > 0) begin
            `CHK("read data", notes[0].e & notes[0].m, prdata_out & notes[0].m)
            `CHK("read error", notes[0].err, pslverr_out)
            void'(notes.pop_front());
        end
    end
    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [31:0] p [3];
        logic [31:0] e1, st;
        repeat (12) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        rd(`PCL_OFF_IFMAP, 32'h0, 32'hffff, 1'b0);
        rd(8'h40, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, `PCL_OFF_INT_MASK, 32'h3);
        apb(1'b1, `PCL_OFF_LOCKOUT, 32'd40);
        for (int s = 0; s < 3; s++) begin
            // Clear flags left by the previous run so the capture flag is seen fresh
            apb(1'b1, `PCL_OFF_INT_STAT, 32'h7);
            look(1'b0, 1'b0, 1);
            p = '{rnd(), rnd(), rnd()};
            st = (s == 1) ? 32'd798 : 32'(5 + s);
            pcl_axis_model_inst.set_pos(p[0], p[1], p[2]);
            pcl_axis_model_inst.set_idle(s == 1);
            apb(1'b1, `PCL_OFF_SRC, 32'(s));
            apb(1'b1, `PCL_OFF_COUNT, 32'd2);
            apb(1'b1, `PCL_OFF_START, st);
            apb(1'b1, `PCL_OFF_CTRL, {30'h0, s == 1, 1'b1});
            rd(`PCL_OFF_IFMAP, 32'h0100, 32'hffff, 1'b0);
            `CHK("input map", `PCL_IFMAP_FORCED, ifmap)
            e1 = p[s];
            pcl_axis_model_inst.fire();
            look(1'b0, 1'b1, 100);
            apb(1'b1, `PCL_OFF_INT_STAT, 32'h1);
            pcl_axis_model_inst.fire();
            rd(`PCL_OFF_COUNT, 32'd1, 32'h3ff, 1'b0);
            look(1'b1, 1'b0, 1);
            p = '{rnd(), rnd(), rnd()};
            pcl_axis_model_inst.set_pos(p[0], p[1], p[2]);
            repeat (40) @(posedge clk_sys_in);
            pcl_axis_model_inst.fire();
            look(1'b1, 1'b1, 100);
            rd(`PCL_OFF_CTRL, 32'h0, 32'h1, 1'b0);
            rd(`PCL_OFF_COUNT, 32'h0, 32'h3ff, 1'b0);
            apb(1'b1, `PCL_OFF_RD_INDEX, st);
            rd(`PCL_OFF_RD_DATA, e1, 32'hffffffff, 1'b0);
            apb(1'b1, `PCL_OFF_RD_INDEX, st + 32'd1);
            rd(`PCL_OFF_RD_DATA, p[s], 32'hffffffff, 1'b0);
        end
        compare_uses_capture_in <= 1'b1;
        apb(1'b1, `PCL_OFF_SRC, 32'h0);
        rd(`PCL_OFF_SRC, 32'h2, 32'h3, 1'b0);
        compare_uses_capture_in <= 1'b0;
        apb(1'b1, `PCL_OFF_COUNT, 32'h0);
        apb(1'b1, `PCL_OFF_CTRL, 32'h1);
        rd(`PCL_OFF_CTRL, 32'h0, 32'h1, 1'b0);
        look(1'b1, 1'b0, 1);
        apb(1'b1, `PCL_OFF_INT_STAT, 32'h1);
        apb(1'b1, `PCL_OFF_INT_MASK, 32'h0);
        look(1'b0, 1'b0, 1);
        apb(1'b1, `PCL_OFF_INT_MASK, 32'h3);
        look(1'b0, 1'b1, 1);
        apb(1'b1, `PCL_OFF_INT_STAT, 32'h7);
        look(1'b0, 1'b0, 1);
        // Reset again while the map is still forced: it must fall back to default
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        `CHK("input map", `PCL_IFMAP_RESET, ifmap)
        rd(`PCL_OFF_IFMAP, 32'h0, 32'hffff, 1'b0);
        wrap_up();
    end
endmodule
